// ===== common/dtu_map.vh
`ifndef DTU_MAP_VH
`define DTU_MAP_VH
// Register byte offsets on the Wishbone slave.
`define DTU_CTRL_OFS    12'h000
`define DTU_STAT_OFS    12'h004
`define DTU_MASK_OFS    12'h008
`define DTU_DESC_OFS    12'h100
// Control register fields.
`define DTU_CTRL_EN_BIT 0
`define DTU_CTRL_CH_LSB 8
// Descriptor word indexes inside one channel slot.
`define DTU_W_MODE      2'h0
`define DTU_W_SRC       2'h1
`define DTU_W_DST       2'h2
`define DTU_W_CNT       2'h3
// Mode word fields.
`define DTU_MD_LSB      0
`define DTU_MD_MSB      1
`define DTU_SZ_BIT      2
`define DTU_SM_LSB      3
`define DTU_SM_MSB      4
`define DTU_DM_LSB      5
`define DTU_DM_MSB      6
`define DTU_AREA_BIT    7
`define DTU_IRQSEL_BIT  8
// Transfer modes.
`define DTU_MODE_NORMAL 2'h0
`define DTU_MODE_REPEAT 2'h1
`define DTU_MODE_BLOCK  2'h2
// Address step selections.
`define DTU_AM_FIXED    2'h0
`define DTU_AM_INC      2'h1
`define DTU_AM_DEC      2'h2
// Reset values.
`define DTU_CTRL_RST    32'h0000_0000
`define DTU_MASK_RST    8'h00
`endif

// ===== rtl/dtu_top.v
// How it works
// - Normal mode moves one byte or word per accepted activation.
// - Normal count spans 1 to 65,536; reaching the end raises an interrupt.
// - Memory-side address steps by 1 for bytes, by 2 for words.
// - Repeat mode moves one unit per activation, count 1 to 256.
// - Repeat expiry reloads running count and repeat-area address, then continues.
// - Repeat mode raises no interrupt unless the per-transfer select is set.
// - Repeat keeps reload in upper count byte, live count in lower byte.
// - Normal mode runs the first count word; second count word unused.
// - Source and destination addresses are separate 24-bit entries.
// - Block mode moves a whole block for one activation.
// - Block size spans 1 to 256 units of byte or word.
// - Exactly one of source or destination is the block area.
// - Each activation fetches the descriptor, transfers, then writes it back.
// - Source and destination independently increment, decrement or hold.
// - Per-transfer select set raises an interrupt after that transfer.
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "dtu_map.vh"
module dtu_top #(
  parameter NCH = 8,
  parameter AW  = 24
) (
  // Clock and reset
  input  wire              mclk,
  input  wire              reset_n,
  input  wire              clk_en,
  // Wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [11:0]       wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  // Activation sources
  input  wire [NCH-1:0]    act_req,
  output reg  [NCH-1:0]    act_done_q,
  // Internal data bus master
  output reg               mem_req_q,
  output reg               mem_we_q,
  output reg               mem_word_q,
  output reg  [AW-1:0]     mem_addr_q,
  output reg  [15:0]       mem_wdata_q,
  input  wire [15:0]       mem_rdata,
  input  wire              mem_ack,
  // Interrupt
  output reg               irq_q
);

  localparam S_IDLE  = 3'h0;
  localparam S_FETCH = 3'h1;
  localparam S_RD    = 3'h2;
  localparam S_WR    = 3'h3;
  localparam S_WB    = 3'h4;
  localparam CW      = (NCH > 1) ? $clog2(NCH) : 1;

  reg [31:0]     desc_mem [0:NCH*4-1];
  reg [2:0]      state_q;
  reg [CW-1:0]   ch_q;
  reg [31:0]     mode_q;
  reg [AW-1:0]   src_q;
  reg [AW-1:0]   dst_q;
  reg [15:0]     first_count_word_q;
  reg [15:0]     second_count_word_q;
  reg [15:0]     data_q;
  reg            end_q;
  reg [31:0]     ctrl_q;
  reg [NCH-1:0]  stat_q;
  reg [NCH-1:0]  mask_q;

  wire [1:0]     mode   = mode_q[`DTU_MD_MSB:`DTU_MD_LSB];
  wire           word   = mode_q[`DTU_SZ_BIT];
  wire [1:0]     sm     = mode_q[`DTU_SM_MSB:`DTU_SM_LSB];
  wire [1:0]     dm     = mode_q[`DTU_DM_MSB:`DTU_DM_LSB];
  wire           area_s = mode_q[`DTU_AREA_BIT];
  wire           per_transfer_irq_select = mode_q[`DTU_IRQSEL_BIT];
  wire [7:0]     count_reload_byte       = first_count_word_q[15:8];
  wire [7:0]     count_running_byte      = first_count_word_q[7:0];

  // Lowest numbered enabled request wins.
  // A channel whose done pulse is out this cycle is skipped, so a source
  // that drops its request at that edge does not start a second run.
  reg            pend;
  reg [CW-1:0]   pick;
  reg [NCH-1:0]  cand;
  integer        i;
  always @* begin
    pend = 1'b0;
    pick = {CW{1'b0}};
    cand = act_req & ctrl_q[`DTU_CTRL_CH_LSB +: NCH] & ~act_done_q;
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        pend = 1'b1;
        pick = i[CW-1:0];
      end
    end
  end

  // Step of one unit along an address, or none when held.
  function [AW-1:0] step;
    input [AW-1:0] a;
    input [1:0]    am;
    input          w;
    reg   [AW-1:0] d;
    begin
      d = w ? {{(AW-2){1'b0}}, 2'b10} : {{(AW-1){1'b0}}, 1'b1};
      case (am)
        `DTU_AM_INC: step = a + d;
        `DTU_AM_DEC: step = a - d;
        default:     step = a;
      endcase
    end
  endfunction

  // Walks an area address back to its first unit; n of zero means 256.
  // It is called on the last unit, so it undoes n-1 steps, not n, and the
  // area address comes back exactly where software first placed it.
  function [AW-1:0] rewind;
    input [AW-1:0] a;
    input [1:0]    am;
    input          w;
    input [7:0]    n;
    reg   [8:0]    nn;
    reg   [AW-1:0] b;
    begin
      nn = (n == 8'h00) ? 9'h100 : {1'b0, n};
      nn = nn - 9'h001;
      b  = w ? {{(AW-10){1'b0}}, nn, 1'b0} : {{(AW-9){1'b0}}, nn};
      case (am)
        `DTU_AM_INC: rewind = a - b;
        `DTU_AM_DEC: rewind = a + b;
        default:     rewind = a;
      endcase
    end
  endfunction

  // Per-unit bookkeeping, settled once the write of a unit is acknowledged.
  // Every address and count update is worked out here in one place, so the
  // engine only decides when to take it. Repeat and block modes share the
  // reload of the running count byte and the rewind of the area address.
  reg [AW-1:0]   src_d;
  reg [AW-1:0]   dst_d;
  reg [15:0]     first_count_word_d;
  reg [15:0]     second_count_word_d;
  reg            last_d;
  reg            end_d;
  reg            wrap;
  always @* begin
    src_d               = step(src_q, sm, word);
    dst_d               = step(dst_q, dm, word);
    first_count_word_d  = first_count_word_q - 16'h0001;
    second_count_word_d = second_count_word_q;
    last_d              = 1'b1;
    end_d               = 1'b0;
    wrap                = (count_running_byte == 8'h01);
    case (mode)
      `DTU_MODE_NORMAL: begin
        end_d = (first_count_word_q == 16'h0001);
      end
      `DTU_MODE_REPEAT: begin
        // The running byte reloads at one instead of counting down to zero, so no end event exists.
        first_count_word_d = {count_reload_byte, count_running_byte - 8'h01};
        if (wrap) begin
          first_count_word_d = {count_reload_byte, count_reload_byte};
          if (area_s)
            src_d = rewind(src_q, sm, word, count_reload_byte);
          else
            dst_d = rewind(dst_q, dm, word, count_reload_byte);
        end
      end
      `DTU_MODE_BLOCK: begin
        first_count_word_d = {count_reload_byte, count_running_byte - 8'h01};
        last_d             = wrap;
        if (wrap) begin
          first_count_word_d  = {count_reload_byte, count_reload_byte};
          second_count_word_d = second_count_word_q - 16'h0001;
          end_d               = (second_count_word_q == 16'h0001);
          if (area_s)
            src_d = rewind(src_q, sm, word, count_reload_byte);
          else
            dst_d = rewind(dst_q, dm, word, count_reload_byte);
        end
      end
      default: begin
        end_d = 1'b0;
      end
    endcase
  end

  // Bus decode. The engine's write-back owns the descriptor array, so bus
  // access waits out that one cycle instead of racing it.
  wire           wb_hit  = wb_cyc_i & wb_stb_i & ~wb_ack_o & (state_q != S_WB);
  wire           is_desc = (wb_adr_i >= `DTU_DESC_OFS) && (wb_adr_i < `DTU_DESC_OFS + NCH * 16);
  wire [11:0]    d_off   = wb_adr_i - `DTU_DESC_OFS;
  wire [CW+1:0]  d_idx   = d_off[CW+3:2];
  // A status read clears the sticky bits, but an event in the same cycle
  // is kept, so no interrupt is lost to a read that races it.
  wire           rd_stat = wb_hit & ~wb_we_i & (wb_adr_i == `DTU_STAT_OFS);
  wire [31:0]    wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Only the end of the count or a per-transfer select raises an event;
  // repeat mode never ends, so it relies on the select alone.
  wire           fire    = (state_q == S_WB) & (end_q | per_transfer_irq_select);
  wire [NCH-1:0] set_v   = fire ? ({{(NCH-1){1'b0}}, 1'b1} << ch_q) : {NCH{1'b0}};
  wire [NCH-1:0] stat_d  = (rd_stat ? {NCH{1'b0}} : stat_q) | set_v;

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_q   <= `DTU_CTRL_RST;
      mask_q   <= `DTU_MASK_RST;
      stat_q   <= {NCH{1'b0}};
      irq_q    <= 1'b0;
    end else if (clk_en) begin
      wb_ack_o <= wb_hit;
      stat_q   <= stat_d;
      irq_q    <= |(stat_d & mask_q);
      if (wb_hit && wb_we_i) begin
        if (wb_adr_i == `DTU_CTRL_OFS)
          ctrl_q <= (ctrl_q & ~wmask) | (wb_dat_i & wmask);
        if (wb_adr_i == `DTU_MASK_OFS && wb_sel_i[0])
          mask_q <= wb_dat_i[NCH-1:0];
      end
      if (wb_hit && !wb_we_i) begin
        if (wb_adr_i == `DTU_CTRL_OFS)
          wb_dat_o <= ctrl_q;
        else if (wb_adr_i == `DTU_STAT_OFS)
          wb_dat_o <= {{(31-NCH){1'b0}}, state_q != S_IDLE, stat_q};
        else if (wb_adr_i == `DTU_MASK_OFS)
          wb_dat_o <= {{(32-NCH){1'b0}}, mask_q};
        else if (is_desc)
          wb_dat_o <= desc_mem[d_idx];
        else
          wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // Descriptor array: written by software, or by the engine at write-back.
  // It has no reset, so software must fill a slot before enabling its channel.
  always @(posedge mclk) begin
    if (clk_en) begin
      if (state_q == S_WB) begin
        desc_mem[{ch_q, `DTU_W_SRC}] <= {{(32-AW){1'b0}}, src_q};
        desc_mem[{ch_q, `DTU_W_DST}] <= {{(32-AW){1'b0}}, dst_q};
        desc_mem[{ch_q, `DTU_W_CNT}] <= {second_count_word_q, first_count_word_q};
      end else if (wb_hit && wb_we_i && is_desc) begin
        desc_mem[d_idx] <= (desc_mem[d_idx] & ~wmask) | (wb_dat_i & wmask);
      end
    end
  end

  // Transfer engine.
  // One unit is a read request followed by a write request, each held until
  // its acknowledge. A slow bus only stretches the wait; nothing times out,
  // so a partner that never answers leaves the engine busy.
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= S_IDLE;
      ch_q        <= {CW{1'b0}};
      mode_q      <= 32'h0000_0000;
      src_q       <= {AW{1'b0}};
      dst_q       <= {AW{1'b0}};
      first_count_word_q  <= 16'h0000;
      second_count_word_q <= 16'h0000;
      data_q      <= 16'h0000;
      end_q       <= 1'b0;
      act_done_q  <= {NCH{1'b0}};
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_word_q  <= 1'b0;
      mem_addr_q  <= {AW{1'b0}};
      mem_wdata_q <= 16'h0000;
    end else if (clk_en) begin
      act_done_q <= {NCH{1'b0}};
      case (state_q)
        S_IDLE: begin
          end_q <= 1'b0;
          if (ctrl_q[`DTU_CTRL_EN_BIT] && pend) begin
            ch_q    <= pick;
            state_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          mode_q  <= desc_mem[{ch_q, `DTU_W_MODE}];
          src_q   <= desc_mem[{ch_q, `DTU_W_SRC}][AW-1:0];
          dst_q   <= desc_mem[{ch_q, `DTU_W_DST}][AW-1:0];
          first_count_word_q  <= desc_mem[{ch_q, `DTU_W_CNT}][15:0];
          second_count_word_q <= desc_mem[{ch_q, `DTU_W_CNT}][31:16];
          state_q <= S_RD;
        end
        S_RD: begin
          // A byte is kept in the low lane with the high lane cleared, so the
          // write that follows never carries stale upper bits.
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            data_q    <= word ? mem_rdata : {8'h00, mem_rdata[7:0]};
            state_q   <= S_WR;
          end else if (!mem_req_q) begin
            mem_req_q  <= 1'b1;
            mem_we_q   <= 1'b0;
            mem_word_q <= word;
            mem_addr_q <= src_q;
          end
        end
        S_WR: begin
          if (mem_ack) begin
            mem_req_q <= 1'b0;
            mem_we_q  <= 1'b0;
            src_q     <= src_d;
            dst_q     <= dst_d;
            first_count_word_q  <= first_count_word_d;
            second_count_word_q <= second_count_word_d;
            end_q     <= end_d;
            state_q   <= last_d ? S_WB : S_RD;
          end else if (!mem_req_q) begin
            mem_req_q   <= 1'b1;
            mem_we_q    <= 1'b1;
            mem_addr_q  <= dst_q;
            mem_wdata_q <= data_q;
          end
        end
        S_WB: begin
          // The done pulse follows write-back, so a source that restarts at
          // once always finds the updated descriptor in the array.
          act_done_q <= {{(NCH-1){1'b0}}, 1'b1} << ch_q;
          state_q    <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // dtu_top

// ===== testbench/dtu_props.sv
`timescale 1ns/100ps
module dtu_props #(
  parameter NCH = 8,
  parameter AW  = 24
) (
  input wire logic           mclk,
  input wire logic           reset_n,
  input wire logic           wb_stb_i,
  input wire logic           wb_we_i,
  input wire logic [11:0]    wb_adr_i,
  input wire logic [31:0]    wb_dat_o,
  input wire logic           wb_ack_o,
  input wire logic [NCH-1:0] act_done_q,
  input wire logic           mem_req_q,
  input wire logic           mem_we_q,
  input wire logic           mem_word_q,
  input wire logic [AW-1:0]  mem_addr_q,
  input wire logic [15:0]    mem_wdata_q,
  input wire logic [15:0]    mem_rdata,
  input wire logic           mem_ack,
  input wire logic           irq_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence rd_done;
    mem_req_q && !mem_we_q && mem_ack;
  endsequence
  sequence wr_start;
    mem_req_q && mem_we_q;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_bound_a: assert property ($rose(wb_stb_i) |-> ##[1:2] wb_ack_o) else $error("ack late");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 12'h00C |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  req_hold_a: assert property (mem_req_q && !mem_ack |=> mem_req_q && $stable(mem_addr_q) && $stable(mem_we_q))
    else $error("bus request dropped");
  wr_follows_a: assert property (rd_done |=> !mem_req_q ##1 wr_start) else $error("no write");
  wr_data_a: assert property (rd_done |=> ##1 mem_wdata_q[7:0] == $past(mem_rdata[7:0], 2) &&
    (!mem_word_q || mem_wdata_q[15:8] == $past(mem_rdata[15:8], 2))) else $error("data changed");
  done_pulse_a: assert property (|act_done_q |=> act_done_q == '0) else $error("done too long");
  done_one_a: assert property ($onehot0(act_done_q)) else $error("two done bits");
  irq_clear_a: assert property ($fell(irq_q) |-> $past(wb_stb_i) || $past(wb_stb_i, 2))
    else $error("irq fell alone");
endmodule // dtu_props

// ===== testbench/dtu_mem.sv
`timescale 1ns/100ps
module dtu_mem (
  // Clock, reset and pacing
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        slow,
  // Data bus from the engine
  input  wire logic        mem_req_q,
  input  wire logic [23:0] mem_addr_q,
  output logic      [15:0] mem_rdata,
  output logic             mem_ack
);
  logic wait_q;
  logic junk_q;
  // Outside an answer the read lines toggle, so a stale sample cannot pass.
  assign mem_rdata = mem_ack ? (mem_addr_q[15:0] ^ 16'h5A3C) : {16{junk_q}};
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      wait_q <= 1'b0;
      junk_q <= 1'b0;
    end else begin
      junk_q <= ~junk_q;
      mem_ack <= mem_req_q && !mem_ack && (wait_q || !slow);
      wait_q <= mem_req_q && !mem_ack && !wait_q && slow;
    end
  end
endmodule // dtu_mem

// ===== testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic        mclk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow, irq_q, clk_en;
  logic        mem_req_q, mem_we_q, mem_word_q, mem_ack;
  logic [11:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0]  act_req, act_done_q;
  logic [23:0] mem_addr_q, s, d, i;
  logic [15:0] mem_wdata_q, mem_rdata, lf;
  logic [39:0] exp_q[$];
  integer      error_cnt, cmp_count;
  dtu_top #(.NCH(8), .AW(24)) dut(.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .act_req(act_req), .act_done_q(act_done_q),
    .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_word_q(mem_word_q), .mem_addr_q(mem_addr_q),
    .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq_q(irq_q));
  dtu_mem mem(.mclk(mclk), .reset_n(reset_n), .slow(slow), .mem_req_q(mem_req_q),
    .mem_addr_q(mem_addr_q), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  always @(posedge mclk) begin
    lf <= nxt(lf);
    slow <= lf[0];
  end
  task report_and_stop;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task tmo;
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    report_and_stop;
  endtask
  task chk(input logic [39:0] seen, input logic [39:0] want);
    cmp_count++;
    if (seen !== want) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task wb(input logic we, input logic [11:0] a, input logic [31:0] dt);
    integer n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) tmo;
    @(posedge mclk);
  endtask
  task desc(input logic [3:0] ch, input logic [31:0] md, input logic [31:0] cn);
    wb(1'b1, {4'h1, ch, 4'h0}, md);
    wb(1'b1, {4'h1, ch, 4'h4}, {8'h00, s});
    wb(1'b1, {4'h1, ch, 4'h8}, {8'h00, d});
    wb(1'b1, {4'h1, ch, 4'hC}, cn);
  endtask
  task ex(input logic [23:0] a, input logic [23:0] sa, input logic w);
    exp_q.push_back({a, (sa[15:0] ^ 16'h5A3C) & (w ? 16'hFFFF : 16'h00FF)});
  endtask
  task act(input integer ch);
    integer n;
    act_req[ch] <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (act_done_q[ch] !== 1'b1 && n < 100);
    act_req[ch] <= 1'b0;
    if (n >= 100) tmo;
    repeat (2) @(posedge mclk);
  endtask
  // Each finished write is matched against the oldest noted transfer.
  always @(posedge mclk) begin
    if (reset_n && mem_req_q && mem_we_q && mem_ack) begin
      if (exp_q.size() == 0) chk(40'h1, 40'h0);
      else chk({mem_addr_q, mem_wdata_q & (mem_word_q ? 16'hFFFF : 16'h00FF)}, exp_q.pop_front());
    end
  end
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    lf = 16'h0047;
    slow = 1'b0;
    clk_en = 1'b1;
    reset_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 12'h000;
    wb_dat_i = 32'h0;
    act_req = 8'h00;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    wb(1'b0, 12'h000, 32'h0);
    chk(rd, 40'h0);
    wb(1'b1, 12'h00C, 32'hFFFFFFFF);
    wb(1'b0, 12'h00C, 32'h0);
    chk(rd, 40'h0);
    wb(1'b1, 12'h000, 32'h00000701);
    wb(1'b1, 12'h008, 32'h00000005);
    s = {lf, 8'h00};
    d = s ^ 24'h800000;
    desc(4'h0, 32'h0000004C, 32'h00000002);
    for (i = 0; i < 2; i++) begin
      ex(d - (i << 1), s + (i << 1), 1'b1);
      act(0);
      chk(irq_q, i == 1);
    end
    // A request seen only while the clock enable is low must start nothing.
    clk_en <= 1'b0;
    act_req[0] <= 1'b1;
    repeat (3) @(posedge mclk);
    act_req[0] <= 1'b0;
    @(posedge mclk);
    clk_en <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(mem_req_q, 1'b0);
    chk(irq_q, 1'b1);
    wb(1'b0, 12'h004, 32'h0);
    chk(rd[8:0], 9'h001);
    chk(irq_q, 1'b0);
    wb(1'b0, 12'h104, 32'h0);
    chk(rd, {8'h00, s + 24'h4});
    wb(1'b0, 12'h108, 32'h0);
    chk(rd, {8'h00, d - 24'h4});
    wb(1'b0, 12'h10C, 32'h0);
    chk(rd[15:0], 16'h0000);
    s = {lf, 8'h00};
    desc(4'h1, 32'h00000089, 32'h00000202);
    for (i = 0; i < 3; i++) begin
      ex(d, s + (i & 24'h1), 1'b0);
      act(1);
    end
    wb(1'b0, 12'h004, 32'h0);
    chk(rd[8:0], 9'h000);
    wb(1'b0, 12'h114, 32'h0);
    chk(rd, {8'h00, s + 24'h1});
    wb(1'b0, 12'h11C, 32'h0);
    chk(rd[15:0], 16'h0201);
    wb(1'b1, 12'h110, 32'h00000189);
    ex(d, s + 24'h1, 1'b0);
    act(1);
    chk(irq_q, 1'b0);
    wb(1'b0, 12'h004, 32'h0);
    chk(rd[8:0], 9'h002);
    s = {lf, 8'h00};
    desc(4'h2, 32'h0000002A, 32'h00010202);
    ex(d, s, 1'b0);
    ex(d + 24'h1, s + 24'h1, 1'b0);
    act(2);
    chk(irq_q, 1'b1);
    wb(1'b0, 12'h004, 32'h0);
    chk(rd[8:0], 9'h004);
    wb(1'b0, 12'h124, 32'h0);
    chk(rd, {8'h00, s + 24'h2});
    wb(1'b0, 12'h128, 32'h0);
    chk(rd, {8'h00, d});
    wb(1'b0, 12'h12C, 32'h0);
    chk(rd, 40'h00000202);
    chk(exp_q.size(), 40'h0);
    report_and_stop;
  end
endmodule // testbench
bind dtu_top dtu_props #(.NCH(NCH), .AW(AW)) u_props(.mclk(mclk), .reset_n(reset_n), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .act_done_q(act_done_q),
  .mem_req_q(mem_req_q), .mem_we_q(mem_we_q), .mem_word_q(mem_word_q), .mem_addr_q(mem_addr_q),
  .mem_wdata_q(mem_wdata_q), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq_q(irq_q));
